// [src/eb_pkg.sv]
// constants, field layout and register map of the external bus bank configuration block
//
// Summary of operation
// - four DRAM bank configuration registers, banks four to seven.
// - DRAM bank: base select 0:7, size 8:10, usage 11:12, line fill 13.
// - DRAM bank: early row strobe 14, width 15:16, mux select 17, type bit 31.
// - DRAM timing: row-col 18, page mode 20, first 21:22, burst 23:24, precharge 25.
// - DRAM refresh: alternate mode 19, row strobe on refresh 26, rate 27:30.
// - SRAM bank: burst 14, width 15:16, ready enable 17, wait count 18:23.
// - SRAM bank: strobe delays 24 to 27, hold 28:30, bit 31 reads zero in banks zero to three.
// - after reset banks one and two are disabled and decode nothing.
// - flash decodes cacheable at 0xFFF00000 and noncacheable at 0x7FF00000.
// - DRAM decodes cacheable at 0x00000000 and noncacheable at 0x80000000.
// - serial at 0x7E000000 and Ethernet at 0xF4000000, both noncacheable.
// - Ethernet interrupt on input zero, serial on input one, high level.
// - interrupt polarity and triggering come from the I/O configuration register.
// - size codes 000 to 110 give 1 to 64 MB, base aligned to size.
// - address bits 1:3 of 000 go to DRAM, 111 to SRAM, else reserved.
package eb_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  OFF_BANK0      = 8'h00;
   localparam logic [7:0]  OFF_BANK_LAST  = 8'h1C;
   localparam logic [7:0]  OFF_IO_CONFIG  = 8'h20;
   localparam logic [7:0]  OFF_INSTR_CACHE = 8'h24;
   localparam logic [7:0]  OFF_DATA_CACHE = 8'h28;
   localparam logic [7:0]  OFF_STATUS     = 8'h2C;
   localparam int          NUM_BANKS      = 8;
   localparam int          FIRST_DRAM_BANK = 4;
   localparam logic [31:0] RESET_BANK     = 32'h0000_0000;
   localparam logic [31:0] RESET_CACHE    = 32'h0000_0000;
   localparam logic [31:0] RESET_IO_CONFIG = 32'h0000_0000;

   // ----------------------------------------------------------------
   // bank fields, bit 0 of the register is the MSB
   // ----------------------------------------------------------------
   localparam int BASE_HI = 31, BASE_LO = 24;
   localparam int SIZE_HI = 23, SIZE_LO = 21;
   localparam int USAGE_HI = 20, USAGE_LO = 19;
   localparam int SEQ_LINE_FILL = 18;
   localparam int EARLY_ROW_STROBE = 17;
   localparam int BUS_WIDTH_HI = 16, BUS_WIDTH_LO = 15;
   localparam int ADDR_MUX_SELECT = 14;
   localparam int ROW_COL_TIMING = 13;
   localparam int ALT_REFRESH = 12;
   localparam int PAGE_MODE = 11;
   localparam int FIRST_ACC_HI = 10, FIRST_ACC_LO = 9;
   localparam int BURST_ACC_HI = 8, BURST_ACC_LO = 7;
   localparam int PRECHARGE = 6;
   localparam int ROW_STROBE_ON_REFRESH = 5;
   localparam int REFRESH_RATE_HI = 4, REFRESH_RATE_LO = 1;
   localparam int SRAM_DRAM_SEL = 0;
   localparam int BURST_ENABLE = 17;
   localparam int READY_INPUT_ENABLE = 14;
   localparam int TRANSFER_WAIT_HI = 13, TRANSFER_WAIT_LO = 8;
   localparam int CHIP_SELECT_ON_DELAY = 7;
   localparam int OUTPUT_ENABLE_ON_DELAY = 6;
   localparam int WRITE_BYTE_ON_DELAY = 5;
   localparam int WRITE_BYTE_OFF_DELAY = 4;
   localparam int HOLD_HI = 3, HOLD_LO = 1;
   localparam int SRAM_RESERVED = 0;
   localparam logic [2:0] SIZE_CODE_MAX = 3'h6;
   localparam logic [1:0] USAGE_OFF = 2'h0;

   // ----------------------------------------------------------------
   // address fields of an access, bit 0 is the MSB
   // ----------------------------------------------------------------
   localparam int REGION_HI = 30, REGION_LO = 28;
   localparam int ABASE_HI = 27, ABASE_LO = 20;
   localparam int CREG_HI = 31, CREG_LO = 27;
   localparam logic [2:0] REGION_DRAM = 3'h0;
   localparam logic [2:0] REGION_SRAM = 3'h7;

   // ----------------------------------------------------------------
   // I/O configuration and status fields
   // ----------------------------------------------------------------
   localparam int IRQ0_POL = 0, IRQ0_EDGE = 1, IRQ1_POL = 2, IRQ1_EDGE = 3;
   localparam int DRAM_READ_CLOCK = 4, EDO_MODE = 5;
   localparam int ST_LEVEL_LO = 0, ST_PEND_LO = 2;
   localparam int ST_HIT = 4, ST_RESERVED = 5;
   localparam int IRQ_N = 2;
endpackage

// [src/eb_bank_if.sv]
// bank configuration and lookup result between the register bank and one bank matcher
`timescale 1ns/10ps
interface eb_bank_if;
   logic [31:0] cfg;
   logic [31:0] addr;
   logic        hit;
   logic        dram;
   modport ctrl (output cfg, output addr, input hit, input dram);
   modport dec  (input cfg, input addr, output hit, output dram);
endinterface

// [src/eb_bank_match.sv]
// address match of one bank against its configuration register
`timescale 1ns/10ps
module eb_bank_match #(
   parameter bit DRAM_OK = 1'b0
) (
   eb_bank_if.dec bus
);
   logic [2:0] size_w;
   logic [7:0] mask_w;
   logic [7:0] base_w;
   logic [2:0] region_w;
   logic       dram_w;
   logic       region_ok_w;
   logic       base_ok_w;
   logic       enabled_w;

   assign size_w   = bus.cfg[eb_pkg::SIZE_HI:eb_pkg::SIZE_LO];
   assign base_w   = bus.cfg[eb_pkg::BASE_HI:eb_pkg::BASE_LO];
   assign region_w = bus.addr[eb_pkg::REGION_HI:eb_pkg::REGION_LO];
   // size code masks
   // low base bits below the size are don't care
   assign mask_w   = 8'(8'hFF << size_w);
   assign base_ok_w = ((bus.addr[eb_pkg::ABASE_HI:eb_pkg::ABASE_LO] ^ base_w) & mask_w) == 8'h00;
   // type bit selects
   // banks below four can never describe DRAM
   assign dram_w   = DRAM_OK && !bus.cfg[eb_pkg::SRAM_DRAM_SEL];
   assign region_ok_w = dram_w ? (region_w == eb_pkg::REGION_DRAM) : (region_w == eb_pkg::REGION_SRAM);
   assign enabled_w = (bus.cfg[eb_pkg::USAGE_HI:eb_pkg::USAGE_LO] != eb_pkg::USAGE_OFF)
                      && (size_w <= eb_pkg::SIZE_CODE_MAX);
   assign bus.hit  = enabled_w && region_ok_w && base_ok_w;
   assign bus.dram = dram_w;
endmodule

// [src/eb_bank_config.sv]
// bank configuration registers, board address decode and external interrupt conditioning
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module eb_bank_config (
   input  wire logic                      clk_i,
   input  wire logic                      resetn_i,
   input  wire logic [eb_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [31:0]               wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [31:0]               rdata_o,
   input  wire logic                      acc_valid_i,
   input  wire logic [31:0]               acc_addr_i,
   input  wire logic                      acc_instr_i,
   output logic                           acc_ack_o,
   output logic                           acc_hit_o,
   output logic      [2:0]                acc_bank_o,
   output logic                           acc_dram_o,
   output logic                           acc_sram_o,
   output logic                           acc_reserved_o,
   output logic                           acc_cacheable_o,
   output logic      [31:0]               acc_cfg_o,
   input  wire logic                      ext_irq_zero_i,
   input  wire logic                      ext_irq_one_i,
   output logic      [1:0]                irq_req_o,
   output logic                           dram_read_clock_o,
   output logic                           edo_mode_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [31:0]            bank_q [eb_pkg::NUM_BANKS];
   logic [31:0]            io_config_reg_q;
   logic [31:0]            instr_cacheability_reg_q;
   logic [31:0]            data_cacheability_reg_q;
   logic [31:0]            rdata_q;
   logic                   ack_q;
   logic                   hit_q;
   logic [2:0]             bank_idx_q;
   logic                   dram_q;
   logic                   sram_q;
   logic                   reserved_q;
   logic                   cacheable_q;
   logic [31:0]            cfg_q;
   logic [eb_pkg::IRQ_N-1:0] sync1_q;
   logic [eb_pkg::IRQ_N-1:0] sync2_q;
   logic [eb_pkg::IRQ_N-1:0] sync3_q;
   logic [eb_pkg::IRQ_N-1:0] level_q;
   logic [eb_pkg::IRQ_N-1:0] active_prev_q;
   logic [eb_pkg::IRQ_N-1:0] pend_q;
   logic [eb_pkg::IRQ_N-1:0] pend_d;
   logic [eb_pkg::IRQ_N-1:0] irq_q;
   logic                   ser_written_q;
   logic                   eth_written_q;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   logic       bank_sel_w;
   logic [2:0] bank_wr_idx_w;
   logic       sel_io_w;
   logic       sel_icache_w;
   logic       sel_dcache_w;
   logic       sel_status_w;
   logic [31:0] bank_wdata_w;
   logic [31:0] status_w;
   logic [31:0] rmux_w;

   assign bank_sel_w    = (addr_i <= eb_pkg::OFF_BANK_LAST) && (addr_i[1:0] == 2'h0);
   assign bank_wr_idx_w = addr_i[4:2];
   assign sel_io_w      = addr_i == eb_pkg::OFF_IO_CONFIG;
   assign sel_icache_w  = addr_i == eb_pkg::OFF_INSTR_CACHE;
   assign sel_dcache_w  = addr_i == eb_pkg::OFF_DATA_CACHE;
   assign sel_status_w  = addr_i == eb_pkg::OFF_STATUS;

   // reserved bit zero
   // low banks only hold SRAM, so the type bit cannot be set there
   assign bank_wdata_w = {wdata_i[31:1],
                          wdata_i[eb_pkg::SRAM_DRAM_SEL] && (int'(bank_wr_idx_w) >= eb_pkg::FIRST_DRAM_BANK)};

   assign status_w = {26'h0, reserved_q, hit_q, pend_q, level_q};

   always_comb
   begin
      if (bank_sel_w)
         rmux_w = bank_q[bank_wr_idx_w];
      else if (sel_io_w)
         rmux_w = io_config_reg_q;
      else if (sel_icache_w)
         rmux_w = instr_cacheability_reg_q;
      else if (sel_dcache_w)
         rmux_w = data_cacheability_reg_q;
      else if (sel_status_w)
         rmux_w = status_w;
      else
         rmux_w = 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // full-word bank storage
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         for (int i = 0; i < eb_pkg::NUM_BANKS; i++)
            bank_q[i] <= eb_pkg::RESET_BANK;
      end
      else if (wr_i && bank_sel_w)
         bank_q[bank_wr_idx_w] <= bank_wdata_w;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         io_config_reg_q          <= eb_pkg::RESET_IO_CONFIG;
         instr_cacheability_reg_q <= eb_pkg::RESET_CACHE;
         data_cacheability_reg_q  <= eb_pkg::RESET_CACHE;
      end
      else if (wr_i)
      begin
         if (sel_io_w)
            io_config_reg_q <= wdata_i;
         if (sel_icache_w)
            instr_cacheability_reg_q <= wdata_i;
         if (sel_dcache_w)
            data_cacheability_reg_q <= wdata_i;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rdata_q <= 32'h0000_0000;
      else
         rdata_q <= rd_i ? rmux_w : 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic [eb_pkg::NUM_BANKS-1:0] hit_w;
   logic [eb_pkg::NUM_BANKS-1:0] dram_w;
   logic [2:0]  first_w;
   logic        any_hit_w;
   logic [2:0]  region_w;
   logic        region_rsvd_w;
   logic [4:0]  creg_w;
   logic        cache_bit_w;

   for (genvar g = 0; g < eb_pkg::NUM_BANKS; g++)
   begin : g_bank
      eb_bank_if u_if ();
      assign u_if.cfg  = bank_q[g];
      assign u_if.addr = acc_addr_i;
      assign hit_w[g]  = u_if.hit;
      assign dram_w[g] = u_if.dram;
      eb_bank_match #(
         .DRAM_OK (g >= eb_pkg::FIRST_DRAM_BANK)
      ) u_match (
         .bus (u_if.dec)
      );
   end

   // lowest bank wins; overlapping banks are a software error anyway
   always_comb
   begin
      first_w = 3'h0;
      for (int i = eb_pkg::NUM_BANKS - 1; i >= 0; i--)
         if (hit_w[i])
            first_w = 3'(i);
   end

   assign region_w      = acc_addr_i[eb_pkg::REGION_HI:eb_pkg::REGION_LO];
   assign region_rsvd_w = (region_w != eb_pkg::REGION_DRAM) && (region_w != eb_pkg::REGION_SRAM);
   assign any_hit_w     = |hit_w;
   // alias by MSB
   // one cacheability bit per 128MB region, bit 31 covers region 0
   assign creg_w        = acc_addr_i[eb_pkg::CREG_HI:eb_pkg::CREG_LO];
   assign cache_bit_w   = acc_instr_i ? instr_cacheability_reg_q[5'h1F - creg_w]
                                      : data_cacheability_reg_q[5'h1F - creg_w];

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ack_q       <= 1'b0;
         hit_q       <= 1'b0;
         bank_idx_q  <= 3'h0;
         dram_q      <= 1'b0;
         sram_q      <= 1'b0;
         reserved_q  <= 1'b0;
         cacheable_q <= 1'b0;
         cfg_q       <= 32'h0000_0000;
      end
      else
      begin
         ack_q       <= acc_valid_i;
         hit_q       <= acc_valid_i && any_hit_w;
         bank_idx_q  <= first_w;
         dram_q      <= acc_valid_i && any_hit_w && dram_w[first_w];
         sram_q      <= acc_valid_i && any_hit_w && !dram_w[first_w];
         reserved_q  <= acc_valid_i && region_rsvd_w;
         cacheable_q <= acc_valid_i && any_hit_w && cache_bit_w;
         cfg_q       <= any_hit_w ? bank_q[first_w] : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // external interrupts
   // ----------------------------------------------------------------
   logic [eb_pkg::IRQ_N-1:0] pol_w;
   logic [eb_pkg::IRQ_N-1:0] edge_w;
   logic [eb_pkg::IRQ_N-1:0] active_w;
   logic [eb_pkg::IRQ_N-1:0] clr_w;

   assign pol_w    = {io_config_reg_q[eb_pkg::IRQ1_POL], io_config_reg_q[eb_pkg::IRQ0_POL]};
   assign edge_w   = {io_config_reg_q[eb_pkg::IRQ1_EDGE], io_config_reg_q[eb_pkg::IRQ0_EDGE]};
   assign active_w = level_q ~^ pol_w;
   assign clr_w    = (wr_i && sel_status_w) ? wdata_i[eb_pkg::ST_PEND_LO +: eb_pkg::IRQ_N] : '0;
   // set wins over a clear in the same cycle
   assign pend_d   = (pend_q & ~clr_w) | (edge_w & active_w & ~active_prev_q);

   // input zero Ethernet, one serial
   // a level is accepted once the second and third stages agree
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sync1_q       <= '0;
         sync2_q       <= '0;
         sync3_q       <= '0;
         level_q       <= '0;
         active_prev_q <= '0;
         pend_q        <= '0;
         irq_q         <= '0;
      end
      else
      begin
         sync1_q       <= {ext_irq_one_i, ext_irq_zero_i};
         sync2_q       <= sync1_q;
         sync3_q       <= sync2_q;
         level_q       <= (sync2_q & sync3_q) | (level_q & (sync2_q | sync3_q));
         active_prev_q <= active_w;
         pend_q        <= pend_d;
         irq_q         <= (edge_w & pend_d) | (~edge_w & active_w);
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdata_o           = rdata_q;
   assign acc_ack_o         = ack_q;
   assign acc_hit_o         = hit_q;
   assign acc_bank_o        = bank_idx_q;
   assign acc_dram_o        = dram_q;
   assign acc_sram_o        = sram_q;
   assign acc_reserved_o    = reserved_q;
   assign acc_cacheable_o   = cacheable_q;
   assign acc_cfg_o         = cfg_q;
   assign irq_req_o         = irq_q;
   assign dram_read_clock_o = io_config_reg_q[eb_pkg::DRAM_READ_CLOCK];
   assign edo_mode_o        = io_config_reg_q[eb_pkg::EDO_MODE];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   logic any_enabled_w;
   always_comb
   begin
      any_enabled_w = 1'b0;
      for (int i = 0; i < eb_pkg::NUM_BANKS; i++)
         if (bank_q[i][eb_pkg::USAGE_HI:eb_pkg::USAGE_LO] != eb_pkg::USAGE_OFF)
            any_enabled_w = 1'b1;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ser_written_q <= 1'b0;
         eth_written_q <= 1'b0;
      end
      else if (wr_i && bank_sel_w)
      begin
         ser_written_q <= ser_written_q || (bank_wr_idx_w == 3'h1);
         eth_written_q <= eth_written_q || (bank_wr_idx_w == 3'h2);
      end
   end

   a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
      else $error("read data not zero outside read cycle");
   a_bank_read_back: assert property (wr_i && bank_sel_w && int'(bank_wr_idx_w) >= eb_pkg::FIRST_DRAM_BANK
      |=> bank_q[$past(bank_wr_idx_w)] == $past(wdata_i))
      else $error("DRAM bank does not hold the written value");
   a_reset_banks_off: assert property ((!ser_written_q |-> bank_q[1][eb_pkg::USAGE_HI:eb_pkg::USAGE_LO] == 2'h0)
      and (!eth_written_q |-> bank_q[2][eb_pkg::USAGE_HI:eb_pkg::USAGE_LO] == 2'h0))
      else $error("peripheral bank enabled without a write");
   a_sram_bit_zero: assert property (wr_i && bank_sel_w && bank_wr_idx_w < 3'h4
      |=> bank_q[$past(bank_wr_idx_w)][eb_pkg::SRAM_RESERVED] == 1'b0)
      else $error("reserved bit set in low bank");
   a_dram_route_only: assert property (acc_valid_i && region_w == eb_pkg::REGION_DRAM
      |=> !acc_sram_o && !acc_reserved_o)
      else $error("DRAM region routed to SRAM side");
   a_reserved_no_hit: assert property (acc_valid_i && region_rsvd_w |=> acc_reserved_o && !acc_hit_o)
      else $error("reserved region decoded");
   a_usage_zero_off: assert property (acc_valid_i && !any_enabled_w |=> acc_ack_o && !acc_hit_o)
      else $error("hit with every bank disabled");
   a_cache_alias_sel: assert property ((acc_valid_i && any_hit_w && !acc_instr_i && creg_w == 5'h00
      && data_cacheability_reg_q[31] |=> acc_cacheable_o)
      and (acc_valid_i && !acc_instr_i && creg_w == 5'h10 && !data_cacheability_reg_q[15] |=> !acc_cacheable_o))
      else $error("cacheability does not follow region bit");
   a_irq_level_high: assert property ((!edge_w[0] && pol_w[0] && ext_irq_zero_i)[*6] |-> irq_req_o[0])
      else $error("level interrupt zero not raised");
   a_irq_edge_held: assert property (edge_w[1] && pend_q[1] && !(wr_i && sel_status_w) |=> pend_q[1])
      else $error("edge pending lost without clear");

   c_dram_hit: cover property (acc_valid_i ##1 acc_hit_o && acc_dram_o);
   c_sram_hit: cover property (acc_valid_i ##1 acc_hit_o && acc_sram_o && !acc_cacheable_o);
   c_reserved: cover property (acc_valid_i ##1 acc_reserved_o);
   c_edge_irq: cover property (edge_w[0] ##1 irq_req_o[0]);
endmodule

// [test/eb_periph_model.sv]
// far-side model: interrupt pins of the board's network and serial chips
`timescale 1ns/10ps
module eb_periph_model (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [1:0] raise_i,
   output logic            irq_zero_o,
   output logic            irq_one_o
);
   // network on zero, serial on one, high level
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
         {irq_one_o, irq_zero_o} <= 2'h0;
      else
         {irq_one_o, irq_zero_o} <= raise_i;
endmodule

// [test/eb_bank_config_bench.sv]
// self-checking bench for the bank configuration block
`timescale 1ns/10ps
module eb_bank_config_bench;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        rd_q = 1'b0;
   logic        acc_valid_i = 1'b0;
   logic [31:0] acc_addr_i = 32'h0;
   logic        acc_instr_i = 1'b0;
   logic [1:0]  raise = 2'h0;
   logic        ez, eo, dram_read_clock_bit, edo, ack, hit, dr, sr, rs, ca;
   logic [31:0] rdata_o, cfg;
   logic [2:0]  bank;
   logic [1:0]  irq_req_o;
   logic [39:0] q_rd[$], q_acc[$];
   int          fails = 0;
   int          num_checks = 0;

   eb_bank_config eb_bank_config_inst (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .acc_valid_i, .acc_addr_i, .acc_instr_i, .acc_ack_o(ack), .acc_hit_o(hit), .acc_bank_o(bank),
      .acc_dram_o(dr), .acc_sram_o(sr), .acc_reserved_o(rs), .acc_cacheable_o(ca), .acc_cfg_o(cfg),
      .ext_irq_zero_i(ez), .ext_irq_one_i(eo), .irq_req_o, .dram_read_clock_o(dram_read_clock_bit), .edo_mode_o(edo));
   eb_periph_model eb_periph_model_inst (.clk_i, .resetn_i, .raise_i(raise), .irq_zero_o(ez),
      .irq_one_o(eo));

   initial forever #25 clk_i = ~clk_i;

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (fails == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   function automatic logic [39:0] ex(input int h, b, d, s, r, c, input logic [31:0] w);
      return {h[0], b[2:0], d[0], s[0], r[0], c[0], w};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      q_rd.push_back({8'h00, e});
      @(posedge clk_i);
      rd_i <= 1'b0;
   endtask

   task automatic lk(input logic [31:0] a, input logic ins, input logic [39:0] e);
      @(posedge clk_i);
      acc_addr_i <= a;
      acc_instr_i <= ins;
      acc_valid_i <= 1'b1;
      q_acc.push_back(e);
      @(posedge clk_i);
      acc_valid_i <= 1'b0;
   endtask

   // bounded wait, a lapse ends the run
   task automatic wait_irq(input logic [1:0] e);
      for (int n = 0; n < 20 && irq_req_o !== e; n++)
         @(negedge clk_i);
      chk({38'h0, irq_req_o}, {38'h0, e});
      if (irq_req_o !== e)
         close_out();
   endtask

   always @(posedge clk_i) rd_q <= rd_i;
   always @(negedge clk_i)
   begin
      if (rd_q)
         chk({8'h00, rdata_o}, q_rd.pop_front());
      if (ack === 1'b1)
         chk({hit, hit ? bank : 3'h0, dr, sr, rs, ca, cfg}, q_acc.pop_front());
   end

   initial
   begin
      #4_000_000;
      fails++;
      close_out();
   end

   initial
   begin
      logic [31:0] v;
      int          h;
      void'($urandom(32'hDA31));
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      lk(32'h7E00_0000, 1'b0, ex(0, 0, 0, 0, 0, 0, 0));
      wr(8'h1C, 32'h0059_0AB0);
      wr(8'h18, 32'h0459_0AB0);
      wr(8'h00, 32'hFF18_0242);
      wr(8'h04, 32'hE018_0468);
      wr(8'h08, 32'h4018_46F4);
      wr(8'h24, 32'h8000_0001);
      wr(8'h28, 32'h8000_0001);
      rd(8'h1C, 32'h0059_0AB0);
      rd(8'h08, 32'h4018_46F4);
      rd(8'h30, 32'h0);
      lk(32'h0010_0000, 1'b0, ex(1, 7, 1, 0, 0, 1, 32'h0059_0AB0));
      lk(32'h803F_FFFC, 1'b0, ex(1, 7, 1, 0, 0, 0, 32'h0059_0AB0));
      lk(32'h0050_0000, 1'b0, ex(1, 6, 1, 0, 0, 1, 32'h0459_0AB0));
      lk(32'hFFFF_FFFC, 1'b1, ex(1, 0, 0, 1, 0, 1, 32'hFF18_0242));
      lk(32'h7FF0_0000, 1'b0, ex(1, 0, 0, 1, 0, 0, 32'hFF18_0242));
      lk(32'h7E00_0007, 1'b0, ex(1, 1, 0, 1, 0, 0, 32'hE018_0468));
      lk(32'hF400_003F, 1'b0, ex(1, 2, 0, 1, 0, 0, 32'h4018_46F4));
      lk(32'h1000_0000, 1'b0, ex(0, 0, 0, 0, 1, 0, 0));
      // every size code, last byte inside and first byte past the bank
      for (int sz = 0; sz < 8; sz++)
      begin
         wr(8'h14, 32'h4018_0000 | (sz << 21));
         v = 32'h0400_0000 + (32'h1 << (20 + sz));
         h = (sz < 7);
         lk(v - 1, 1'b0, ex(h, 5 * h, h, 0, 0, h, h ? 32'h4018_0000 | (sz << 21) : 0));
         lk(v, 1'b0, ex(0, 0, 0, 0, 0, 0, 0));
      end
      wr(8'h04, 32'hE000_0468);
      lk(32'h7E00_0000, 1'b0, ex(0, 0, 0, 0, 0, 0, 0));
      wr(8'h20, 32'h14);
      wait_irq(2'b01);
      wr(8'h20, 32'h15);
      wait_irq(2'b00);
      chk({38'h0, dram_read_clock_bit, edo}, {38'h0, 2'b10});
      raise <= 2'b01;
      wait_irq(2'b01);
      raise <= 2'b11;
      wait_irq(2'b11);
      raise <= 2'b00;
      wait_irq(2'b00);
      wr(8'h20, 32'h25);
      repeat (2) @(negedge clk_i);
      chk({38'h0, dram_read_clock_bit, edo}, {38'h0, 2'b01});
      // edge mode on both inputs: requests hold until cleared
      wr(8'h20, 32'h0000_002F);
      raise <= 2'b11;
      wait_irq(2'b11);
      raise <= 2'b00;
      repeat (8) @(negedge clk_i);
      wait_irq(2'b11);
      rd(8'h2C, 32'h0000_000C);
      wr(8'h2C, 32'h0000_000C);
      wait_irq(2'b00);
      repeat (4)
      begin
         v = $urandom;
         wr(8'h10, v);
         rd(8'h10, v);
         wr(8'h0C, v);
         rd(8'h0C, v & 32'hFFFF_FFFE);
      end
      repeat (3) @(negedge clk_i);
      chk(40'(q_rd.size() + q_acc.size()), 40'h0);
      close_out();
   end
endmodule
